// File: common/fwb_defs.svh
`ifndef FWB_DEFS_SVH
`define FWB_DEFS_SVH

// Rates of the two clocks, in MHz
`define FWB_SYS_MHZ 200
`define FWB_BUS_MHZ 66
// Least count of system cycles between two bus clock edges (rounded down)
`define FWB_SYS_PER_BUS (`FWB_SYS_MHZ / `FWB_BUS_MHZ)

// Data-rate selector codes
`define FWB_RATE_2X 2'h0
`define FWB_RATE_4X 2'h1
`define FWB_RATE_8X 2'h2

// Doublewords moved per bus clock at each rate
`define FWB_LANES_2X 5'h02
`define FWB_LANES_4X 5'h04
`define FWB_LANES_8X 5'h08

// Bytes per doubleword and doublewords per upstream word
`define FWB_DW_BYTES 16'h0004
`define FWB_DW_PER_WORD 4
// Initial block the target must take without flow control
`define FWB_INIT_BLOCK_BYTES 16'h0080

`endif

// File: common/fwb_pkg.sv
package fwb_pkg;

  localparam int FWB_MAX_LANES = 8;
  localparam int FWB_WORD_DW = 4;

  // One upstream write word: four doublewords at ascending addresses
  typedef struct packed {
    logic [31:0] addr;
    logic [FWB_WORD_DW*32-1:0] data;
    logic [FWB_WORD_DW*4-1:0] be;
    logic last;
  } fwb_wr_t;

  // Fast-write bus outputs, changed once per bus clock
  typedef struct packed {
    logic frame;
    logic addr_phase;
    logic strobe;
    logic [31:0] addr;
    logic [FWB_MAX_LANES-1:0] lane_valid;
    logic [FWB_MAX_LANES*4-1:0] lane_be;
    logic [FWB_MAX_LANES*32-1:0] data;
  } fwb_bus_t;

  typedef enum logic [3:0] {
    FWB_IDLE = 4'h1,
    FWB_ADDR = 4'h2,
    FWB_DATA = 4'h4,
    FWB_END = 4'h8
  } fwb_state_t;

endpackage : fwb_pkg

// File: design/fwb_fifo.sv
`timescale 1ns/1ps

module fwb_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input wire logic clk,                 // System clock
  input wire logic rst_n,               // Synchronous reset
  input wire logic in_valid,            // Write word offered
  output logic in_ready,                // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word written
  output logic out_valid,               // Head word present
  input wire logic out_ready,           // Head word taken
  output logic [WIDTH-1:0] out_data     // Head word
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_rd_ptr;
  logic [AW-1:0] next_wr_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;
  logic next_in_ready;

  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    // Registered so the upstream ready comes straight from a flop
    next_in_ready = (next_count != DEPTH[AW:0]);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
    end
  end

  // Storage needs no reset; only words below count are ever read out
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : fwb_fifo

// File: design/fwb_bridge.sv
// What this block does
// - Turn each processor write burst into fast write
// - PCI addressing, 2x/4x/8x data, flow control
// - Sequential doublewords from start address upward
// - Address phase takes one bus clock
// - Bus timing counted in 66 MHz bus clocks
// - At 8x, eight doublewords per bus clock
// - 128 bytes at 8x: one plus four clocks
`timescale 1ns/1ps
`include "fwb_defs.svh"

module fwb_bridge
  import fwb_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int ACC_DW = 16
)
(
  input wire logic clk,            // System clock, 200 MHz
  input wire logic rst_n,          // Synchronous reset
  input wire logic wr_valid,       // Upstream write word offered
  output logic wr_ready,           // Upstream word accepted
  input wire fwb_wr_t wr_word,     // Upstream write word
  input wire logic [1:0] rate_sel, // Data rate for new transfers
  input wire logic bus_clk,        // Fast-write bus clock pin
  input wire logic target_rdy,     // Target ready for next block
  output fwb_bus_t bus             // Fast-write bus outputs
);

  function automatic logic [4:0] fwb_lanes(input logic [1:0] rate);
    case (rate)
      `FWB_RATE_2X: fwb_lanes = `FWB_LANES_2X;
      `FWB_RATE_4X: fwb_lanes = `FWB_LANES_4X;
      default: fwb_lanes = `FWB_LANES_8X;
    endcase
  endfunction : fwb_lanes

  // Valid doublewords in a word: all for a full word, up to the top enabled one for the last
  function automatic logic [2:0] fwb_dw_count(input fwb_wr_t w);
    logic [2:0] n;
    n = 3'(FWB_WORD_DW);
    if (w.last)
    begin
      n = 3'h0;
      for (int j = 0; j < FWB_WORD_DW; j++)
      begin
        if (w.be[j*4 +: 4] != 4'h0)
        begin
          n = 3'(j + 1);
        end
      end
    end
    fwb_dw_count = n;
  endfunction : fwb_dw_count

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus clock edge detect

  logic [2:0] clk_sync;
  logic [1:0] rdy_sync;
  logic [2:0] next_clk_sync;
  logic [1:0] next_rdy_sync;
  logic bus_edge;
  logic rdy_s;

  always_comb
  begin
    next_clk_sync = {clk_sync[1:0], bus_clk};
    next_rdy_sync = {rdy_sync[0], target_rdy};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      clk_sync <= 3'h0;
      rdy_sync <= 2'h0;
    end
    else
    begin
      clk_sync <= next_clk_sync;
      rdy_sync <= next_rdy_sync;
    end
  end

  // Every bus-side action waits for this pulse, once per bus clock
  assign bus_edge = clk_sync[1] && !clk_sync[2];
  assign rdy_s = rdy_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Ingress FIFO

  logic fifo_valid;
  logic fifo_pop;
  fwb_wr_t head;

  fwb_fifo #(
    .WIDTH($bits(fwb_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(head)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transaction engine

  fwb_state_t state;
  fwb_state_t next_state;
  logic [31:0] acc_d [ACC_DW];
  logic [3:0] acc_be [ACC_DW];
  logic [31:0] next_acc_d [ACC_DW];
  logic [3:0] next_acc_be [ACC_DW];
  logic [4:0] acc_n;
  logic [4:0] next_acc_n;
  logic burst_done;
  logic next_burst_done;
  logic [15:0] bytes_sent;
  logic [15:0] next_bytes_sent;
  logic [4:0] lanes;
  logic [4:0] next_lanes;
  fwb_bus_t next_bus;
  logic take;
  logic [4:0] k;
  logic [2:0] pop_n;
  logic flow_ok;

  always_comb
  begin
    int src;
    int pos;
    src = 0;
    pos = 0;
    next_state = state;
    next_acc_n = acc_n;
    next_burst_done = burst_done;
    next_bytes_sent = bytes_sent;
    next_lanes = lanes;
    next_bus = bus;
    take = 1'b0;
    k = 5'h00;
    // Data stalls for the target only once the initial block has gone
    flow_ok = rdy_s || (bytes_sent < `FWB_INIT_BLOCK_BYTES);
    if (state == FWB_DATA && bus_edge && acc_n != 5'h00 && flow_ok &&
        (acc_n >= lanes || burst_done))
    begin
      take = 1'b1;
      k = (acc_n >= lanes) ? lanes : acc_n;
    end
    // No pop before the address is out: head must still hold the start address
    fifo_pop = (state == FWB_DATA) && fifo_valid && !burst_done &&
               (acc_n <= 5'(ACC_DW - FWB_WORD_DW));
    pop_n = fifo_pop ? fwb_dw_count(head) : 3'h0;
    for (int i = 0; i < ACC_DW; i++)
    begin
      src = i + int'(k);
      next_acc_d[i] = (src < ACC_DW) ? acc_d[src] : 32'h0000_0000;
      next_acc_be[i] = (src < ACC_DW) ? acc_be[src] : 4'h0;
    end
    for (int j = 0; j < FWB_WORD_DW; j++)
    begin
      pos = int'(acc_n) - int'(k) + j;
      if (j < int'(pop_n) && pos < ACC_DW)
      begin
        next_acc_d[pos] = head.data[j*32 +: 32];
        next_acc_be[pos] = head.be[j*4 +: 4];
      end
    end
    next_acc_n = acc_n - k + 5'(pop_n);
    if (fifo_pop && head.last)
    begin
      next_burst_done = 1'b1;
    end

    case (state)
      FWB_IDLE:
      begin
        next_burst_done = 1'b0;
        next_bytes_sent = 16'h0000;
        if (fifo_valid)
        begin
          next_lanes = fwb_lanes(rate_sel);
          next_state = FWB_ADDR;
        end
      end
      FWB_ADDR:
      begin
        if (bus_edge)
        begin
          next_bus.frame = 1'b1;
          next_bus.addr = head.addr;
          next_bus.addr_phase = 1'b1;
          next_state = FWB_DATA;
        end
      end
      FWB_DATA:
      begin
        if (bus_edge)
        begin
          next_bus.addr_phase = 1'b0;
          next_bus.strobe = take;
          for (int i = 0; i < FWB_MAX_LANES; i++)
          begin
            next_bus.lane_valid[i] = take && (i < int'(k));
            next_bus.data[i*32 +: 32] = (i < int'(k)) ? acc_d[i] : 32'h0000_0000;
            next_bus.lane_be[i*4 +: 4] = (take && i < int'(k)) ? acc_be[i] : 4'h0;
          end
          if (take)
          begin
            next_bytes_sent = bytes_sent + 16'(k) * `FWB_DW_BYTES;
          end
          if (burst_done && acc_n == k)
          begin
            next_state = FWB_END;
          end
        end
      end
      FWB_END:
      begin
        if (bus_edge)
        begin
          next_bus.frame = 1'b0;
          next_bus.strobe = 1'b0;
          next_bus.lane_valid = '0;
          next_bus.lane_be = '0;
          next_state = FWB_IDLE;
        end
      end
      default:
      begin
        next_state = FWB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= FWB_IDLE;
      acc_n <= 5'h00;
      burst_done <= 1'b0;
      bytes_sent <= 16'h0000;
      lanes <= `FWB_LANES_8X;
      bus <= '0;
      for (int i = 0; i < ACC_DW; i++)
      begin
        acc_d[i] <= 32'h0000_0000;
        acc_be[i] <= 4'h0;
      end
    end
    else
    begin
      state <= next_state;
      acc_n <= next_acc_n;
      burst_done <= next_burst_done;
      bytes_sent <= next_bytes_sent;
      lanes <= next_lanes;
      bus <= next_bus;
      acc_d <= next_acc_d;
      acc_be <= next_acc_be;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_addr_one_clock;
    @(posedge clk) disable iff (!rst_n)
    (bus.addr_phase && bus_edge) |=> !bus.addr_phase;
  endproperty
  a_addr_one_clock: assert property (p_addr_one_clock) else $error("address phase longer than one bus clock");

  property p_addr_then_data;
    @(posedge clk) disable iff (!rst_n)
    bus.strobe |-> (bus.frame && !bus.addr_phase);
  endproperty
  a_addr_then_data: assert property (p_addr_then_data) else $error("data outside a framed data phase");

  property p_bus_edge_only;
    @(posedge clk) disable iff (!rst_n)
    !bus_edge |=> $stable(bus);
  endproperty
  a_bus_edge_only: assert property (p_bus_edge_only) else $error("bus changed between bus clock edges");

  property p_lane_limit;
    @(posedge clk) disable iff (!rst_n)
    bus.strobe |-> ($countones(bus.lane_valid) <= int'(lanes) && bus.lane_valid[0]);
  endproperty
  a_lane_limit: assert property (p_lane_limit) else $error("more doublewords than the rate allows");

  property p_lanes_contiguous;
    @(posedge clk) disable iff (!rst_n)
    bus.strobe |-> ((bus.lane_valid & (bus.lane_valid + 8'h01)) == 8'h00);
  endproperty
  a_lanes_contiguous: assert property (p_lanes_contiguous) else $error("valid lanes not sequential");

  property p_flow_hold;
    @(posedge clk) disable iff (!rst_n)
    (bus_edge && state == FWB_DATA && !rdy_s && bytes_sent >= `FWB_INIT_BLOCK_BYTES) |=> !bus.strobe;
  endproperty
  a_flow_hold: assert property (p_flow_hold) else $error("data sent while target throttles");

  property p_full_lane_go;
    @(posedge clk) disable iff (!rst_n)
    (bus_edge && state == FWB_DATA && acc_n >= lanes && bytes_sent < `FWB_INIT_BLOCK_BYTES)
      |=> (bus.strobe && $countones(bus.lane_valid) == int'(lanes));
  endproperty
  a_full_lane_go: assert property (p_full_lane_go) else $error("full beat held back in initial block");

  property p_idle_lanes_quiet;
    @(posedge clk) disable iff (!rst_n)
    !bus.strobe |-> (bus.lane_valid == 8'h00 && bus.lane_be == 32'h0000_0000);
  endproperty
  a_idle_lanes_quiet: assert property (p_idle_lanes_quiet) else $error("byte enables outside a data beat");

  property p_pop_framed;
    @(posedge clk) disable iff (!rst_n)
    fifo_pop |-> (state != FWB_IDLE && state != FWB_END);
  endproperty
  a_pop_framed: assert property (p_pop_framed) else $error("write taken outside a transaction");

  property p_edge_spacing;
    @(posedge clk) disable iff (!rst_n)
    bus_edge |=> !bus_edge [*2];
  endproperty
  a_edge_spacing: assert property (p_edge_spacing) else $error("bus clock faster than expected");

endmodule : fwb_bridge

// File: tb/fwb_target.sv
`timescale 1ns/1ps

module fwb_target
  import fwb_pkg::*;
(
  input wire logic bus_clk, // Fast-write bus clock
  input wire logic rst_n,   // Reset, active low
  input wire fwb_bus_t bus, // Bridge outputs
  input wire logic stall,   // Throttle once the first block is in
  output logic target_rdy   // Ready for the next block
);
  logic [15:0] bytes;
  logic [15:0] next_bytes;
  logic [2:0] phase;
  logic [2:0] next_phase;
  logic next_rdy;

  always_comb
  begin
    next_bytes = bytes;
    next_phase = (phase == 3'h4) ? 3'h0 : phase + 3'h1;
    if (bus.frame && bus.addr_phase)
      next_bytes = 16'h0000;
    else if (bus.strobe)
      next_bytes = bytes + 16'($countones(bus.lane_valid)) * 16'h0004;
    // Buffer holds the first block whole; later it fills, 3 busy clocks in 5
    next_rdy = !(stall && next_bytes >= 16'h0080 && next_phase < 3'h3);
  end

  // Asynchronous clear: reset may end before the first bus clock edge
  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bytes <= 16'h0000;
      phase <= 3'h0;
      target_rdy <= 1'b1;
    end
    else
    begin
      bytes <= next_bytes;
      phase <= next_phase;
      target_rdy <= next_rdy;
    end
  end
endmodule : fwb_target

// File: tb/write_to_fast_write_bridge_bench.sv
`timescale 1ns/1ps
`include "fwb_defs.svh"

module write_to_fast_write_bridge_bench
  import fwb_pkg::*;
;
  typedef struct {int n; int lanes; logic stall; logic [31:0] start;} fwb_tx_t;
  logic clk, rst_n, wr_valid, wr_ready, bus_clk, target_rdy, stall, in_tx, saw_full, saw_wait;
  logic [1:0] rate_sel;
  logic [31:0] seed;
  logic [35:0] e;
  fwb_wr_t wr_word;
  fwb_bus_t bus;
  fwb_tx_t cur;
  fwb_tx_t txq[$];
  logic [35:0] dwq[$];
  int n_errors, compares, cycles, sent, clocks, waits, nl;

  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  // Phase offset keeps bus edges clear of system clock edges
  initial
  begin
    bus_clk = 0;
    #7.3;
    forever #32 bus_clk = ~bus_clk;
  end

  fwb_bridge #(.FIFO_DEPTH(8), .ACC_DW(16)) DUT (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_word(wr_word), .rate_sel(rate_sel), .bus_clk(bus_clk),
    .target_rdy(target_rdy), .bus(bus));
  fwb_target TGT (.bus_clk(bus_clk), .rst_n(rst_n), .bus(bus), .stall(stall), .target_rdy(target_rdy));

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic int lanes_of(input logic [1:0] r);
    return r == `FWB_RATE_2X ? `FWB_LANES_2X : r == `FWB_RATE_4X ? `FWB_LANES_4X : `FWB_LANES_8X;
  endfunction : lanes_of

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // One burst of nw words; top is the last enabled dword of the final word, -1 for none
  task automatic push_burst(input int nw, input int top, input logic [3:0] lbe);
    fwb_tx_t t;
    fwb_wr_t w;
    logic [3:0] b;
    t.start = rnd() & 32'hFFFF_FFFC;
    t.n = (nw - 1) * 4 + top + 1;
    t.lanes = lanes_of(rate_sel);
    t.stall = stall;
    txq.push_back(t);
    for (int i = 0; i < nw; i++)
    begin
      w.addr = t.start + 32'(16 * i);
      w.last = (i == nw - 1);
      for (int j = 0; j < 4; j++)
      begin
        w.data[j*32 +: 32] = rnd();
        b = !w.last || j < top ? 4'hF : (j == top ? lbe : 4'h0);
        w.be[j*4 +: 4] = b;
        if (b != 4'h0)
          dwq.push_back({b, w.data[j*32 +: 32]});
      end
      wr_valid = 1'b1;
      wr_word = w;
      while (wr_ready !== 1'b1)
      begin
        saw_full = 1'b1;
        @(posedge clk);
        #1;
      end
      @(posedge clk);
      #1;
    end
  endtask : push_burst

  task automatic wait_idle();
    int k;
    k = 0;
    wr_valid = 1'b0;
    while ((txq.size() != 0 || in_tx) && k < 20000)
    begin
      @(posedge clk);
      k++;
    end
    #1;
    check(256'(txq.size() != 0 || in_tx), 256'(0));
  endtask : wait_idle

  ////////////////////////////////////////////////////////////
  // Bus fields settle a few system clocks after each bus edge, so sample on the edge
  always @(posedge bus_clk)
  begin
    if (bus.frame === 1'b1 && bus.addr_phase === 1'b1)
    begin
      check(256'(in_tx), 256'(0));
      check(256'(txq.size() != 0), 256'(1));
      cur = txq.pop_front();
      check(256'(bus.addr), 256'(cur.start));
      in_tx = 1'b1;
      clocks = 1;
      waits = 0;
      sent = 0;
    end
    else if (bus.frame === 1'b1)
    begin
      clocks++;
      if (bus.strobe === 1'b1)
      begin
        nl = cur.n - sent < cur.lanes ? cur.n - sent : cur.lanes;
        check(256'(bus.lane_valid), 256'((1 << nl) - 1));
        for (int i = 0; i < nl; i++)
        begin
          e = dwq.pop_front();
          check(256'(bus.data[i*32 +: 32]), 256'(e[31:0]));
          check(256'(bus.lane_be[i*4 +: 4]), 256'(e[35:32]));
        end
        sent += nl;
      end
      else
      begin
        waits++;
        saw_wait = 1'b1;
        // An empty burst shows one framed clock with no beat before the frame drops
        check(256'(cur.n == 0 || (cur.stall && sent >= `FWB_INIT_BLOCK_BYTES / `FWB_DW_BYTES)), 256'(1));
      end
    end
    else if (in_tx)
    begin
      in_tx = 1'b0;
      check(256'(sent), 256'(cur.n));
      check(256'(clocks), 256'(1 + (cur.n + cur.lanes - 1) / cur.lanes + waits));
    end
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h55AB;
    n_errors = 0;
    compares = 0;
    cycles = 0;
    in_tx = 1'b0;
    saw_full = 1'b0;
    saw_wait = 1'b0;
    rst_n = 1'b0;
    wr_valid = 1'b0;
    wr_word = '0;
    rate_sel = `FWB_RATE_8X;
    stall = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check(256'({bus.frame, bus.strobe, bus.lane_valid, wr_ready}), 256'(1));
    push_burst(8, 3, 4'hF);
    wait_idle();
    // Every rate code: two full-tail bursts back to back, then a short flushed one
    for (int r = 0; r < 4; r++)
    begin
      rate_sel = 2'(r);
      push_burst(1 + int'(rnd() % 8), 3, 4'hF);
      push_burst(1 + int'(rnd() % 8), 3, 4'hF);
      push_burst(1 + int'(rnd() % 3), int'(rnd() % 4), 4'h1 | 4'(rnd()));
      wait_idle();
    end
    rate_sel = `FWB_RATE_4X;
    push_burst(1, -1, 4'h0);
    wait_idle();
    stall = 1'b1;
    rate_sel = `FWB_RATE_8X;
    // Longer than the initial block, so the target gets a chance to throttle
    push_burst(12, 3, 4'hF);
    push_burst(8, 2, 4'h3);
    wait_idle();
    check(256'({saw_wait, saw_full}), 256'(3));
    check(256'({wr_ready, dwq.size() == 0}), 256'(3));
    stop_test();
  end
endmodule : write_to_fast_write_bridge_bench
